// >>> rtl/dlm_monitor.sv
// Limit switch, temperature and stall monitor top level
`timescale 1ns/1ps
`default_nettype none
module dlm_monitor
   import dlm_pkg::*;
#(
   parameter longint OVERTEMP_CYCLES = OVERTEMP_CYC,
   parameter int FIELD_W = 8
)(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic reg_wr_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   input wire logic positive_end_switch_in_i,
   input wire logic negative_end_switch_in_i,
   input wire logic homing_switch_in_i,
   input wire logic index_pulse_i,
   input wire logic moving_i,
   input wire logic move_dir_pos_i,
   input wire logic jog_mode_i,
   input wire logic homing_i,
   input wire logic stage_enable_i,
   input wire logic [FIELD_W-1:0] field_angle_i,
   input wire logic signed [15:0] stage_temp_i,
   input wire logic signed [15:0] motor_temp_i,
   output logic motion_stop_o,
   output logic stage_disable_o,
   output logic limit_pos_hit_o,
   output logic limit_neg_hit_o,
   output logic homing_switch_hit_o,
   output logic temp_warn_o,
   output logic temp_error_o,
   output logic stall_o
);
   // Elaboration guard: angle must reach above one pair, timer is 32 bits
   if (FIELD_W < 3 || FIELD_W > 16) begin : g_bad_field
      $error("FIELD_W out of range");
   end
   if (OVERTEMP_CYCLES < 2 ||
      OVERTEMP_CYCLES > 64'h0000_0001_0000_0000) begin : g_bad_ot
      $error("OVERTEMP_CYCLES out of range");
   end
   localparam logic [31:0] OT_LAST = 32'(OVERTEMP_CYCLES - 1);
   localparam logic [FIELD_W-1:0] PAIR_MASK =
      FIELD_W'(FIELD_STEPS_PER_PAIR - 1);

   // ==========================================================
   // Registers
   logic [15:0] positive_limit_eval;
   logic [15:0] negative_limit_eval;
   logic [15:0] homing_switch_eval;
   logic [15:0] stall_detect_enable;
   dlm_reg_req_t req;
   assign req = '{wr: reg_wr_i, addr: reg_addr_i, data: reg_wdata_i};
   // Only the three evaluation fields and stall enable take writes
   wire wr_pos = req.wr && req.addr == REG_POSITIVE_LIMIT_EVAL;
   wire wr_neg = req.wr && req.addr == REG_NEGATIVE_LIMIT_EVAL;
   wire wr_ref = req.wr && req.addr == REG_HOMING_SWITCH_EVAL;
   wire wr_stl = req.wr && req.addr == REG_STALL_DETECT_ENABLE;
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         positive_limit_eval <= EVAL_RESET;
         negative_limit_eval <= EVAL_RESET;
         homing_switch_eval <= EVAL_RESET;
         stall_detect_enable <= STALL_EN_RESET;
      end else begin
         if (wr_pos) positive_limit_eval <= req.data;
         if (wr_neg) negative_limit_eval <= req.data;
         if (wr_ref) homing_switch_eval <= req.data;
         if (wr_stl) stall_detect_enable <= req.data;
      end
   end

   // ==========================================================
   // Switch inputs
   logic pos_raw, neg_raw, ref_raw;
   dlm_switch_eval u_pos (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .pin_i(positive_end_switch_in_i), .eval_i(positive_limit_eval),
      .hit_o(pos_raw));
   dlm_switch_eval u_neg (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .pin_i(negative_end_switch_in_i), .eval_i(negative_limit_eval),
      .hit_o(neg_raw));
   dlm_switch_eval u_ref (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .pin_i(homing_switch_in_i), .eval_i(homing_switch_eval),
      .hit_o(ref_raw));
   logic idx_meta, idx_sync, idx_prev;

   // Limit hits count only while moving; zone latched until the switch clears
   wire pos_trip = moving_i & pos_raw;
   wire neg_trip = moving_i & neg_raw;
   logic pos_zone, neg_zone;
   // Jog away from a zone is allowed, further travel toward it is not
   wire toward_pos = moving_i & move_dir_pos_i;
   wire toward_neg = moving_i & ~move_dir_pos_i;
   wire jog_out_pos = jog_mode_i & toward_neg;
   wire jog_out_neg = jog_mode_i & toward_pos;
   wire next_stop = (pos_trip & ~jog_out_pos) | (neg_trip & ~jog_out_neg)
      | (pos_zone & toward_pos) | (neg_zone & toward_neg);
   // Reference switch is ignored outside homing
   wire ref_hit = homing_i & ref_raw;

   // ==========================================================
   // Temperature compare against fixed constants
   wire over_s = stage_temp_i > STAGE_T_MAX;
   wire over_m = motor_temp_i > MOTOR_T_MAX;
   wire warn_hit = stage_temp_i >= STAGE_T_WARN
      || motor_temp_i >= MOTOR_T_WARN;
   logic [31:0] ot_cnt;
   logic temp_err;
   wire ot_expire = (over_s | over_m) && ot_cnt == OT_LAST;

   // ==========================================================
   // Stall detection
   logic stall_armed;
   logic [FIELD_W-1:0] ref_angle;
   logic stage_en_q;
   wire idx_rise = idx_sync & ~idx_prev;
   wire stall_on = stall_detect_enable == 16'h0001;
   wire stage_rise = stage_enable_i & ~stage_en_q;
   // Pole pair sits in upper bits; phase within pair is the low bits
   wire pair_diff = ((field_angle_i ^ ref_angle) & ~PAIR_MASK) != '0;
   wire stall_hit = stall_on & stall_armed & moving_i & idx_rise
      & pair_diff;

   // ==========================================================
   // State updates
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idx_meta <= 1'b0;
         idx_sync <= 1'b0;
         idx_prev <= 1'b0;
         stage_en_q <= 1'b0;
      end else begin
         idx_meta <= index_pulse_i;
         idx_sync <= idx_meta;
         idx_prev <= idx_sync;
         stage_en_q <= stage_enable_i;
      end
   end

   // Zone held until the switch clears
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pos_zone <= 1'b0;
         neg_zone <= 1'b0;
      end else begin
         pos_zone <= pos_trip | (pos_zone & pos_raw);
         neg_zone <= neg_trip | (neg_zone & neg_raw);
      end
   end

   // Timer restarts whenever temperature drops back to the limit
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ot_cnt <= 32'h0000_0000;
         temp_err <= 1'b0;
      end else begin
         if (!(over_s | over_m)) ot_cnt <= 32'h0000_0000;
         else if (!ot_expire) ot_cnt <= ot_cnt + 32'h0000_0001;
         if (ot_expire) temp_err <= 1'b1;
      end
   end

   // Disarm on every stage enable, arm and learn angle at first index
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stall_armed <= 1'b0;
         ref_angle <= '0;
      end else if (stage_rise || !stall_on) begin
         stall_armed <= 1'b0;
      end else if (idx_rise && !stall_armed) begin
         stall_armed <= 1'b1;
         ref_angle <= field_angle_i;
      end
   end

   // ==========================================================
   // Outputs, all registered; error is sticky until reset
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         motion_stop_o <= 1'b0;
         stage_disable_o <= 1'b0;
         limit_pos_hit_o <= 1'b0;
         limit_neg_hit_o <= 1'b0;
         homing_switch_hit_o <= 1'b0;
         temp_warn_o <= 1'b0;
         temp_error_o <= 1'b0;
         stall_o <= 1'b0;
      end else begin
         motion_stop_o <= next_stop | ot_expire | temp_err;
         stage_disable_o <= ot_expire | temp_err;
         limit_pos_hit_o <= pos_trip | pos_zone;
         limit_neg_hit_o <= neg_trip | neg_zone;
         homing_switch_hit_o <= ref_hit;
         temp_warn_o <= warn_hit;
         temp_error_o <= ot_expire | temp_err;
         stall_o <= stall_hit | (stall_o & ~stage_rise);
      end
   end

   // ==========================================================
   // Read mux; temperature limits are read-only constants
   logic [15:0] status;
   assign status = {9'h000, homing_switch_hit_o, stall_armed, stall_o,
      temp_error_o, temp_warn_o, limit_neg_hit_o, limit_pos_hit_o};
   logic [15:0] next_rdata;
   always_comb begin
      unique case (reg_addr_i)
         REG_POSITIVE_LIMIT_EVAL: next_rdata = positive_limit_eval;
         REG_NEGATIVE_LIMIT_EVAL: next_rdata = negative_limit_eval;
         REG_HOMING_SWITCH_EVAL: next_rdata = homing_switch_eval;
         REG_STALL_DETECT_ENABLE: next_rdata = stall_detect_enable;
         REG_STAGE_TEMP_WARN: next_rdata = STAGE_T_WARN;
         REG_STAGE_TEMP_MAX: next_rdata = STAGE_T_MAX;
         REG_STAGE_TEMP_ACTUAL: next_rdata = stage_temp_i;
         REG_MONITOR_STATUS: next_rdata = status;
         default: next_rdata = 16'h0000;
      endcase
   end
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) reg_rdata_o <= 16'h0000;
      else reg_rdata_o <= next_rdata;
   end

   // ==========================================================
   // Checks
   limit_stop_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) (pos_trip && !jog_mode_i) |=> motion_stop_o)
      else $error("limit hit did not stop motion");
   limit_flag_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) neg_trip |=> limit_neg_hit_o)
      else $error("negative limit not flagged");
   idle_limit_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) (!moving_i && !pos_zone) |=> !limit_pos_hit_o)
      else $error("limit flagged while idle");
   inactive_eval_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) (positive_limit_eval == EVAL_INACTIVE) |-> !pos_raw)
      else $error("inactive input evaluated");
   ref_homing_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) !homing_i |=> !homing_switch_hit_o)
      else $error("reference evaluated outside homing");
   warn_flag_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) (stage_temp_i >= STAGE_T_WARN) |=> temp_warn_o)
      else $error("warning missed");
   temp_shut_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) temp_error_o |-> stage_disable_o && motion_stop_o)
      else $error("error without shutdown");
   timer_reset_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) (!over_s && !over_m) |=> ot_cnt == 32'h0000_0000)
      else $error("timer not restarted");
   stall_arm_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) stage_rise |=> !stall_armed)
      else $error("stall detection armed after enable");
   refuse_dir_a: assert property (@(posedge ref_clk_i) disable iff
      (!reset_n_i) (pos_zone && toward_pos) |=> motion_stop_o)
      else $error("motion into zone not refused");
endmodule : dlm_monitor
`default_nettype wire

// >>> rtl/dlm_pkg.sv
// Package for the limit, temperature and stall monitor
package dlm_pkg;
   // ==========================================================
   // Register offsets (fieldbus parameter addresses)
   localparam logic [15:0] REG_HOMING_SWITCH_EVAL = 16'h061C;
   localparam logic [15:0] REG_NEGATIVE_LIMIT_EVAL = 16'h061E;
   localparam logic [15:0] REG_POSITIVE_LIMIT_EVAL = 16'h0620;
   localparam logic [15:0] REG_STAGE_TEMP_WARN = 16'h100C;
   localparam logic [15:0] REG_STAGE_TEMP_MAX = 16'h100E;
   localparam logic [15:0] REG_STAGE_TEMP_ACTUAL = 16'h1C20;
   localparam logic [15:0] REG_STALL_DETECT_ENABLE = 16'h141A;
   localparam logic [15:0] REG_MONITOR_STATUS = 16'h1C22;
   // ==========================================================
   // Reset values
   localparam logic [15:0] EVAL_RESET = 16'h0001;
   localparam logic [15:0] STALL_EN_RESET = 16'h0000;
   // ==========================================================
   // Evaluation codes
   localparam logic [15:0] EVAL_INACTIVE = 16'h0000;
   localparam logic [15:0] EVAL_NC = 16'h0001;
   localparam logic [15:0] EVAL_NO = 16'h0002;
   // ==========================================================
   // Fixed temperature limits, degrees C, signed
   localparam logic signed [15:0] STAGE_T_WARN = 16'sh0050;
   localparam logic signed [15:0] STAGE_T_MAX = 16'sh005A;
   localparam logic signed [15:0] MOTOR_T_WARN = 16'sh005F;
   localparam logic signed [15:0] MOTOR_T_MAX = 16'sh0069;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int OVERTEMP_S = 5;
   localparam longint OVERTEMP_CYC = longint'(OVERTEMP_S) * CLK_HZ;
   // Field steps per revolution: 50 pole pairs, 4 full steps each
   localparam int POLE_PAIRS = 50;
   localparam int FIELD_STEPS_PER_PAIR = 4;
   // Status bit positions
   localparam int ST_LIM_POS = 0;
   localparam int ST_LIM_NEG = 1;
   localparam int ST_TEMP_WARN = 2;
   localparam int ST_TEMP_ERR = 3;
   localparam int ST_STALL = 4;
   localparam int ST_STALL_ARMED = 5;
   localparam int ST_REF_HIT = 6;

   // Register write strobe with data
   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [15:0] data;
   } dlm_reg_req_t;
endpackage : dlm_pkg

// >>> rtl/dlm_switch_eval.sv
// One switch input: synchroniser and evaluation decode
`timescale 1ns/1ps
`default_nettype none
module dlm_switch_eval
   import dlm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic pin_i,
   input wire logic [15:0] eval_i,
   output logic hit_o
);
   logic meta;
   logic sync;
   wire is_nc = (eval_i == EVAL_NC);
   wire is_no = (eval_i == EVAL_NO);
   // ==========================================================
   // Two-flop synchroniser; first flop read only by the second
   // Resets high: evaluation resets to NC, so no false trip follows reset
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta <= 1'b1;
         sync <= 1'b1;
      end else begin
         meta <= pin_i;
         sync <= meta;
      end
   end
   // NC trips on low (broken wire also trips), NO on high
   assign hit_o = (is_nc & ~sync) | (is_no & sync);
endmodule : dlm_switch_eval
`default_nettype wire

// >>> tb/dlm_far_side.sv
// Far-side model: end switches, reference switch and index sensor
`timescale 1ns/1ps
`default_nettype none
module dlm_far_side (
   input wire logic ref_clk_i,
   input wire logic pos_reached_i,
   input wire logic neg_reached_i,
   input wire logic ref_reached_i,
   input wire logic pos_nc_i,
   input wire logic neg_nc_i,
   input wire logic ref_nc_i,
   input wire logic index_fire_i,
   output logic positive_end_switch_in_o,
   output logic negative_end_switch_in_o,
   output logic homing_switch_in_o,
   output logic index_pulse_o
);
   // ==========================================================
   // Contacts
   logic [2:0] idx_cnt = 3'h0;
   // Reached NC contact opens and the pin falls; NO closes, pin rises
   assign positive_end_switch_in_o = pos_reached_i ^ pos_nc_i;
   assign negative_end_switch_in_o = neg_reached_i ^ neg_nc_i;
   assign homing_switch_in_o = ref_reached_i ^ ref_nc_i;
   // ==========================================================
   // Index sensor
   // Pulse held several clocks so the synchroniser cannot miss it
   always_ff @(posedge ref_clk_i) begin
      if (index_fire_i && idx_cnt == 3'h0) begin
         idx_cnt <= 3'h7;
      end else if (idx_cnt != 3'h0) begin
         idx_cnt <= idx_cnt - 3'h1;
      end
   end
   assign index_pulse_o = (idx_cnt > 3'h3);
endmodule : dlm_far_side
`default_nettype wire

// >>> tb/tb_dlm_monitor.sv
// Self-checking bench for the limit, temperature and stall monitor
`timescale 1ns/1ps
`default_nettype none
module tb_dlm_monitor;
   import dlm_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0;
   dlm_reg_req_t req = '0;
   logic [15:0] rdata, code, v;
   logic pr = 1'b0, nr = 1'b0, rr = 1'b0, fire = 1'b0;
   logic pnc = 1'b1, nnc = 1'b1, rnc = 1'b1;
   logic pin_p, pin_n, pin_r, idx;
   logic mov = 1'b0, dpos = 1'b0, jog = 1'b0, hom = 1'b0, sten = 1'b0;
   logic [7:0] ang = 8'h00;
   logic signed [15:0] st = 16'sh0014, mt = 16'sh0014;
   logic stop, sdis, hp, hn, hr, warn, terr, stall;
   int fails = 0, total_checks = 0;
   // Clock
   always #12.5 ref_clk_i = ~ref_clk_i;
   dlm_far_side far_u (.ref_clk_i(ref_clk_i), .pos_reached_i(pr),
      .neg_reached_i(nr), .ref_reached_i(rr), .pos_nc_i(pnc),
      .neg_nc_i(nnc), .ref_nc_i(rnc), .index_fire_i(fire),
      .positive_end_switch_in_o(pin_p), .negative_end_switch_in_o(pin_n),
      .homing_switch_in_o(pin_r), .index_pulse_o(idx));
   dlm_monitor #(.OVERTEMP_CYCLES(20)) dut_u (.ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i), .reg_wr_i(req.wr), .reg_addr_i(req.addr),
      .reg_wdata_i(req.data), .reg_rdata_o(rdata),
      .positive_end_switch_in_i(pin_p), .negative_end_switch_in_i(pin_n),
      .homing_switch_in_i(pin_r), .index_pulse_i(idx), .moving_i(mov),
      .move_dir_pos_i(dpos), .jog_mode_i(jog), .homing_i(hom),
      .stage_enable_i(sten), .field_angle_i(ang), .stage_temp_i(st),
      .motor_temp_i(mt), .motion_stop_o(stop), .stage_disable_o(sdis),
      .limit_pos_hit_o(hp), .limit_neg_hit_o(hn),
      .homing_switch_hit_o(hr), .temp_warn_o(warn),
      .temp_error_o(terr), .stall_o(stall));
   // ==========================================================
   // Helpers
   function automatic logic exp_hit(input logic [15:0] c, input logic r);
      return r && (c == EVAL_NC || c == EVAL_NO);
   endfunction : exp_hit
   function automatic logic exp_warn(input logic signed [15:0] s, m);
      return s >= STAGE_T_WARN || m >= MOTOR_T_WARN;
   endfunction : exp_warn
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : cyc
   // Write strobe lasts one clock; an idle clock keeps writes apart
   task automatic wr(input logic [15:0] a, d);
      req = '{1'b1, a, d};
      cyc(1);
      req.wr = 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      req.addr = a;
      cyc(2);
      d = rdata;
   endtask : rd
   task automatic pulse(input logic [7:0] a);
      ang = a;
      fire = 1'b1;
      cyc(1);
      fire = 1'b0;
      cyc(12);
   endtask : pulse
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(25 * 6000);
      fails++;
      test_done();
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(54));
      cyc(10);
      reset_n_i = 1'b1;
      cyc(1);
      rd(REG_POSITIVE_LIMIT_EVAL, v);
      chk("pos eval", v, EVAL_RESET);
      rd(REG_NEGATIVE_LIMIT_EVAL, v);
      chk("neg eval", v, EVAL_RESET);
      rd(REG_HOMING_SWITCH_EVAL, v);
      chk("ref eval", v, EVAL_RESET);
      rd(REG_STALL_DETECT_ENABLE, v);
      chk("stall en", v, STALL_EN_RESET);
      wr(REG_NEGATIVE_LIMIT_EVAL, EVAL_NO);
      rd(REG_NEGATIVE_LIMIT_EVAL, v);
      chk("neg wr", v, EVAL_NO);
      rd(16'h0002, v);
      chk("unmapped", v, 16'h0000);
      wr(REG_STAGE_TEMP_MAX, 16'h1234);
      rd(REG_STAGE_TEMP_MAX, v);
      chk("t max", v, STAGE_T_MAX);
      rd(REG_STAGE_TEMP_WARN, v);
      chk("t warn", v, STAGE_T_WARN);
      rd(REG_STAGE_TEMP_ACTUAL, v);
      chk("t act", v, st);
      $display("registers done");
      // Every evaluation code, reached and not, random direction
      mov = 1'b1;
      for (int c = 0; c < 3; c++) begin
         for (int r = 0; r < 2; r++) begin
            code = 16'(c);
            wr(REG_POSITIVE_LIMIT_EVAL, code);
            wr(REG_NEGATIVE_LIMIT_EVAL, code);
            pnc = (code == EVAL_NC);
            nnc = pnc;
            dpos = 1'($urandom);
            pr = r[0];
            nr = r[0];
            cyc(6);
            chk("pos hit", 16'(hp), 16'(exp_hit(code, r[0])));
            chk("neg hit", 16'(hn), 16'(exp_hit(code, r[0])));
            chk("stop", 16'(stop), 16'(exp_hit(code, r[0])));
            pr = 1'b0;
            nr = 1'b0;
            cyc(6);
         end
      end
      $display("evaluation codes done");
      mov = 1'b0;
      pr = 1'b1;
      cyc(6);
      chk("idle hit", 16'(hp), 16'h0000);
      mov = 1'b1;
      dpos = 1'b1;
      cyc(6);
      chk("zone stop", 16'(stop), 16'h0001);
      jog = 1'b1;
      dpos = 1'b0;
      cyc(3);
      chk("jog away", 16'(stop), 16'h0000);
      dpos = 1'b1;
      cyc(3);
      chk("jog toward", 16'(stop), 16'h0001);
      pr = 1'b0;
      jog = 1'b0;
      cyc(6);
      $display("zone done");
      // Reference switch only during homing
      for (int c = 1; c < 3; c++) begin
         wr(REG_HOMING_SWITCH_EVAL, 16'(c));
         rnc = (c == 1);
         rr = 1'b1;
         cyc(6);
         chk("ref idle", 16'(hr), 16'h0000);
         hom = 1'b1;
         cyc(6);
         chk("ref homing", 16'(hr), 16'h0001);
         rr = 1'b0;
         hom = 1'b0;
         cyc(6);
      end
      $display("homing switch done");
      // Stall: disabled first, then armed by first index
      sten = 1'b1;
      pulse(8'h10);
      pulse(8'h14);
      chk("stall off", 16'(stall), 16'h0000);
      wr(REG_STALL_DETECT_ENABLE, 16'h0001);
      sten = 1'b0;
      cyc(2);
      sten = 1'b1;
      rd(REG_MONITOR_STATUS, v);
      chk("unarmed", 16'(v[ST_STALL_ARMED]), 16'h0000);
      code = 16'($urandom) & 16'h00FC;
      pulse(code[7:0]);
      rd(REG_MONITOR_STATUS, v);
      chk("armed", 16'(v[ST_STALL_ARMED]), 16'h0001);
      pulse(code[7:0] | 8'h03);
      chk("same pair", 16'(stall), 16'h0000);
      pulse(code[7:0] + 8'h04);
      chk("stall", 16'(stall), 16'h0001);
      $display("stall done");
      // Temperatures: random below warning, thresholds, timer restart
      st = 16'($urandom_range(0, 79));
      cyc(3);
      chk("no warn", 16'(warn), 16'(exp_warn(st, mt)));
      st = STAGE_T_WARN;
      cyc(3);
      chk("stage warn", 16'(warn), 16'h0001);
      st = 16'sh0014;
      mt = MOTOR_T_WARN;
      cyc(3);
      chk("motor warn", 16'(warn), 16'h0001);
      mt = 16'sh0014;
      st = STAGE_T_MAX + 16'sh0001;
      cyc(15);
      st = STAGE_T_MAX;
      cyc(2);
      st = STAGE_T_MAX + 16'sh0001;
      cyc(15);
      chk("restart", 16'(terr), 16'h0000);
      cyc(10);
      chk("temp err", 16'(terr), 16'h0001);
      chk("stage off", 16'(sdis), 16'h0001);
      // Mid-run reset clears the sticky error; then the motor overheats
      st = 16'sh0014;
      pnc = 1'b1;
      nnc = 1'b1;
      reset_n_i = 1'b0;
      cyc(2);
      chk("err reset", 16'(terr), 16'h0000);
      reset_n_i = 1'b1;
      cyc(1);
      mt = MOTOR_T_MAX + 16'sh0001;
      cyc(25);
      chk("motor err", 16'(terr), 16'h0001);
      chk("motor stop", 16'(stop), 16'h0001);
      $display("temperature done");
      test_done();
   end
endmodule : tb_dlm_monitor
`default_nettype wire
